// >>> rtl/twe_map.svh
// Notes on behaviour
// [RQ1] Storage is 128 individually addressed eight-bit words, 1024 bits in all.
// [RQ2] Storage forms 32 pages of four bytes; multi-byte writes fill one page.
// [RQ3] A seven-bit word address selects any one of the 128 bytes.
// [RQ4] Nonvolatile write is self-timed, done within 5 ms of the ending stop.
// [RQ5] The master keeps the serial clock at or below 400 kHz.
// [RQ6] Bits are taken on SCL rising and changed after SCL falling.
// [RQ7] SDA is only pulled low or released; a pull-up makes the high.
// [RQ8] SDA changes only with SCL low; changes with SCL high are start/stop.
// [RQ9] SDA falling with SCL high is a start; every command needs one.
// [RQ10] SDA rising with SCL high is a stop and ends the transaction.
// [RQ11] A stop ending a read puts the device into standby.
// [RQ12] Addresses and data move as eight-bit words in both directions.
// [RQ13] The receiver of a word pulls SDA low on its ninth clock.
// [RQ14] The device acknowledges every address and data word it receives.
// [RQ15] Standby at power-up, and after stop once internal work is done.
// [RQ16] Master recovers the bus with up to 9 clocks, then a start.
// [RQ17] First word after start: seven address bits, then direction, 1 reads.
// [RQ18] During the write cycle inputs are ignored and nothing is acknowledged.
// [RQ19] Page write bumps only the low two address bits, wrapping in page.
// [RQ20] Reads continue with address increment while master acks; wraps at top.
// [RQ21] SCL and SDA are synchronised and edge-detected on a faster clock.
// [RQ22] A start in mid-transfer abandons it and restarts address reception.
`ifndef TWE_MAP_SVH
`define TWE_MAP_SVH

`define TWE_DATA_W 8
`define TWE_ADDR_W 7
`define TWE_MEM_WORDS 128
`define TWE_PAGE_BYTES 4
`define TWE_PAGE_COUNT 32
`define TWE_PAGE_IDX_W 2
`define TWE_BIT_CNT_W 4
`define TWE_BITS_PER_WORD 4'h8
`define TWE_LAST_TX_BIT 4'h7
`define TWE_RW_READ 1'b1
`define TWE_SCL_MAX_KHZ 400
`define TWE_WRITE_CYCLE_NS 5000000
`define TWE_CORE_CLK_NS 100
`define TWE_WRITE_CYCLES (`TWE_WRITE_CYCLE_NS / `TWE_CORE_CLK_NS)
`define TWE_XING_MARGIN 8
`define TWE_TIMER_W 32

`endif

// >>> rtl/twe_pkg.sv
`include "twe_map.svh"
package twe_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_WDATA,
    ST_WACK,
    ST_RDATA,
    ST_RACK,
    ST_IGNORE
  } twe_lstate_t;

  typedef struct packed {
    twe_lstate_t state;
    logic [`TWE_BIT_CNT_W-1:0] bitCnt;
    logic [`TWE_DATA_W-1:0] shift;
    logic [`TWE_ADDR_W-1:0] addr;
    logic rw;
    logic mAck;
    logic [`TWE_PAGE_BYTES-1:0][`TWE_DATA_W-1:0] pageBuf;
    logic [`TWE_PAGE_BYTES-1:0] pageVal;
    logic sdaOe;
    logic sclD;
    logic sdaD;
    logic commitTgl;
    logic commit;
  } twe_link_t;

  typedef struct packed {
    logic lastTgl;
    logic busy;
    logic [`TWE_TIMER_W-1:0] cnt;
    logic ackTgl;
    logic standby;
  } twe_timer_t;

  typedef struct packed {
    logic meta;
    logic hold;
  } twe_sync_t;

endpackage

// >>> rtl/twe_xing_if.sv
`timescale 1ns/1ps
interface twe_xing_if;
  logic commitTgl;
  logic ackTgl;
  logic linkIdle;
  modport link (output commitTgl, output linkIdle, input ackTgl);
  modport core (input commitTgl, input linkIdle, output ackTgl);
endinterface

// >>> rtl/twe_sync.sv
`timescale 1ns/1ps
module twe_sync (
  // Clock
  input wire logic clk,
  // Level in and out
  input wire logic d,
  output logic q
);
  import twe_pkg::*;
  twe_sync_t s_reg;
  twe_sync_t s_next;

  // First stage feeds the second stage only
  always_comb begin
    s_next.meta = d;
    s_next.hold = s_reg.meta;
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  assign q = s_reg.hold;
endmodule

// >>> rtl/twe_wr_timer.sv
`timescale 1ns/1ps
`include "twe_map.svh"
module twe_wr_timer #(
  parameter int CYCLES = `TWE_WRITE_CYCLES
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Crossing to the link side
  twe_xing_if.core xing,
  // Status
  output logic standby
);
  import twe_pkg::*;
  localparam logic [`TWE_TIMER_W-1:0] LOAD =
    `TWE_TIMER_W'(CYCLES - `TWE_XING_MARGIN - 1);
  twe_timer_t t_reg;
  twe_timer_t t_next;
  logic tglSync;
  logic idleSync;

  twe_sync u_tgl (.clk(core_clk), .d(xing.commitTgl), .q(tglSync));
  twe_sync u_idle (.clk(core_clk), .d(xing.linkIdle), .q(idleSync));

  // Margin covers both synchroniser delays inside the 5 ms budget
  always_comb begin
    t_next = t_reg;
    if (!t_reg.busy && (tglSync != t_reg.lastTgl)) begin
      t_next.lastTgl = tglSync;
      t_next.busy = 1'b1; // RQ4
      t_next.cnt = LOAD;
    end else if (t_reg.busy) begin
      if (t_reg.cnt == '0) begin
        t_next.busy = 1'b0;
        t_next.ackTgl = t_reg.lastTgl; // RQ4
      end else begin
        t_next.cnt = t_reg.cnt - 1'b1;
      end
    end
    t_next.standby = idleSync & ~t_reg.busy & ~t_next.busy; // RQ15
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      t_reg <= '0;
      t_reg.standby <= 1'b1; // RQ15
    end else begin
      t_reg <= t_next;
    end
  end

  assign xing.ackTgl = t_reg.ackTgl;
  assign standby = t_reg.standby;
endmodule

// >>> rtl/twe_eeprom_slave.sv
`timescale 1ns/1ps
`include "twe_map.svh"
module twe_eeprom_slave #(
  parameter int WRITE_CYCLES = `TWE_WRITE_CYCLES
) (
  // Core clock, reset and status
  input wire logic core_clk,
  input wire logic srst,
  output logic standby,
  // Bus sampling clock
  input wire logic linkClk,
  // Serial bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);
  import twe_pkg::*;

  twe_link_t r_reg;
  twe_link_t r_next;
  logic [`TWE_DATA_W-1:0] mem [0:`TWE_MEM_WORDS-1]; // RQ1
  logic linkRst;
  logic sclSync;
  logic sdaSync;
  logic ackSync;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic busy;
  logic [`TWE_DATA_W-1:0] rdByte;
  logic [`TWE_PAGE_IDX_W-1:0] slot;

  twe_xing_if xing ();

  twe_sync u_rst (.clk(linkClk), .d(srst), .q(linkRst));
  twe_sync u_scl (.clk(linkClk), .d(sclIn), .q(sclSync)); // RQ21
  twe_sync u_sda (.clk(linkClk), .d(sdaIn), .q(sdaSync)); // RQ21
  twe_sync u_ack (.clk(linkClk), .d(xing.ackTgl), .q(ackSync));

  twe_wr_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
    .core_clk(core_clk),
    .srst(srst),
    .xing(xing.core),
    .standby(standby)
  );

  function automatic logic wordFull(input logic [`TWE_BIT_CNT_W-1:0] c);
    return c == `TWE_BITS_PER_WORD; // RQ12
  endfunction

  function automatic logic [`TWE_ADDR_W-1:0] addrInc(
    input logic [`TWE_ADDR_W-1:0] a
  );
    return a + 1'b1; // RQ20
  endfunction

  // Edge detection on the synchronised pins
  assign sclRise = sclSync & ~r_reg.sclD; // RQ21
  assign sclFall = ~sclSync & r_reg.sclD; // RQ21
  assign startSeen = sclSync & r_reg.sclD & r_reg.sdaD & ~sdaSync; // RQ9 RQ8
  assign stopSeen = sclSync & r_reg.sclD & ~r_reg.sdaD & sdaSync; // RQ10

  // Write cycle pending until the core side echoes the toggle
  assign busy = r_reg.commitTgl != ackSync;
  assign slot = r_reg.addr[`TWE_PAGE_IDX_W-1:0];
  assign rdByte = (r_reg.state == ST_RACK) ?
    mem[addrInc(r_reg.addr)] : mem[r_reg.addr];

  always_comb begin
    r_next = r_reg;
    r_next.commit = 1'b0;
    r_next.sclD = sclSync;
    r_next.sdaD = sdaSync;
    if (r_reg.commit) begin
      r_next.pageVal = '0;
    end
    if (startSeen) begin
      // Abandon whatever was under way, buffered page included
      r_next.state = ST_ADDR; // RQ22
      r_next.bitCnt = '0;
      r_next.sdaOe = 1'b0;
      r_next.pageVal = '0; // RQ22
    end else if (stopSeen) begin
      // Only whole bytes are committed; a partial byte is dropped
      if (r_reg.state == ST_WDATA && |r_reg.pageVal && !busy) begin
        r_next.commit = 1'b1; // RQ4
        r_next.commitTgl = ~r_reg.commitTgl;
      end
      r_next.state = ST_IDLE; // RQ10 RQ11
      r_next.sdaOe = 1'b0;
    end else begin
      case (r_reg.state)
        ST_IDLE: begin
          r_next.sdaOe = 1'b0;
        end
        ST_ADDR, ST_WDATA: begin
          if (sclRise && !wordFull(r_reg.bitCnt)) begin
            r_next.shift = {r_reg.shift[`TWE_DATA_W-2:0], sdaSync}; // RQ6
            r_next.bitCnt = r_reg.bitCnt + 1'b1;
          end
          if (sclFall && wordFull(r_reg.bitCnt)) begin
            r_next.bitCnt = '0;
            if (r_reg.state == ST_ADDR) begin
              if (busy) begin
                r_next.state = ST_IGNORE; // RQ18
              end else begin
                r_next.addr = r_reg.shift[`TWE_DATA_W-1:1]; // RQ17 RQ3
                r_next.rw = r_reg.shift[0]; // RQ17
                r_next.state = ST_AACK;
                r_next.sdaOe = 1'b1; // RQ14 RQ13
              end
            end else begin
              r_next.pageBuf[slot] = r_reg.shift; // RQ2
              r_next.pageVal[slot] = 1'b1;
              r_next.addr[`TWE_PAGE_IDX_W-1:0] = slot + 1'b1; // RQ19
              r_next.state = ST_WACK;
              r_next.sdaOe = 1'b1; // RQ14
            end
          end
        end
        ST_AACK: begin
          if (sclFall) begin
            r_next.bitCnt = '0;
            if (r_reg.rw == `TWE_RW_READ) begin
              r_next.shift = rdByte;
              r_next.sdaOe = ~rdByte[`TWE_DATA_W-1]; // RQ6 RQ7
              r_next.state = ST_RDATA;
            end else begin
              r_next.sdaOe = 1'b0;
              r_next.state = ST_WDATA;
            end
          end
        end
        ST_WACK: begin
          if (sclFall) begin
            r_next.sdaOe = 1'b0; // RQ13
            r_next.state = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (sclFall) begin
            if (r_reg.bitCnt == `TWE_LAST_TX_BIT) begin
              // Release for the master's acknowledge bit
              r_next.sdaOe = 1'b0; // RQ13
              r_next.bitCnt = '0;
              r_next.state = ST_RACK;
            end else begin
              r_next.shift = {r_reg.shift[`TWE_DATA_W-2:0], 1'b0};
              r_next.sdaOe = ~r_reg.shift[`TWE_DATA_W-2]; // RQ6 RQ7
              r_next.bitCnt = r_reg.bitCnt + 1'b1;
            end
          end
        end
        ST_RACK: begin
          if (sclRise) begin
            r_next.mAck = ~sdaSync;
          end
          if (sclFall) begin
            if (r_reg.mAck) begin
              r_next.addr = addrInc(r_reg.addr); // RQ20
              r_next.shift = rdByte;
              r_next.sdaOe = ~rdByte[`TWE_DATA_W-1];
              r_next.state = ST_RDATA;
            end else begin
              r_next.state = ST_IGNORE; // RQ20
            end
          end
        end
        ST_IGNORE: begin
          r_next.sdaOe = 1'b0;
        end
        default: begin
          r_next.state = ST_IDLE;
          r_next.sdaOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      r_reg <= '0;
      r_reg.sclD <= 1'b1;
      r_reg.sdaD <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Page commit lands one cycle after the stop, while the buffer holds
  always_ff @(posedge linkClk) begin
    for (int i = 0; i < `TWE_PAGE_BYTES; i++) begin
      if (r_reg.commit && r_reg.pageVal[i]) begin
        mem[{r_reg.addr[`TWE_ADDR_W-1:`TWE_PAGE_IDX_W],
             `TWE_PAGE_IDX_W'(i)}] <= r_reg.pageBuf[i]; // RQ2 RQ19
      end
    end
  end

  assign xing.commitTgl = r_reg.commitTgl;
  assign xing.linkIdle = (r_reg.state == ST_IDLE) | (r_reg.state == ST_IGNORE);
  assign sdaOut = 1'b0; // RQ7
  assign sdaOe = r_reg.sdaOe; // RQ7
endmodule

// >>> bench/twe_eeprom_slave_asserts.sv
`timescale 1ns/1ps
module twe_eeprom_slave_asserts (
  // Clocks and reset
  input wire logic core_clk,
  input wire logic linkClk,
  input wire logic srst,
  // Pins
  input wire logic standby,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  sequence startSeen;
    sclIn && $past(sclIn) && $fell(sdaIn);
  endsequence
  sequence stopSeen;
    sclIn && $past(sclIn) && $rose(sdaIn);
  endsequence
  chk_pin_low: assert property (@(posedge linkClk)
    disable iff (srst) !sdaOut) else $error("SDA driven high");
  chk_oe_scl_low: assert property (@(posedge linkClk)
    disable iff (srst) $changed(sdaOe) |-> !sclIn)
    else $error("SDA drive changed with SCL high");
  // Sync delay means SCL was already low two samples back
  chk_oe_after_fall: assert property (@(posedge linkClk)
    disable iff (srst) $changed(sdaOe) |-> !$past(sclIn, 2))
    else $error("SDA drive changed too soon after SCL fall");
  chk_oe_holds: assert property (@(posedge linkClk)
    disable iff (srst) $rose(sdaOe) |-> sdaOe [*8])
    else $error("SDA drive shorter than one bit");
  chk_start_listen: assert property (@(posedge linkClk)
    disable iff (srst) startSeen |-> !sdaOe [*8])
    else $error("SDA driven during address reception");
  chk_stop_release: assert property (@(posedge linkClk)
    disable iff (srst) stopSeen |=> !sdaOe [*8])
    else $error("SDA driven after stop");
  chk_idle_quiet: assert property (@(posedge core_clk)
    disable iff (srst) standby |-> !sdaOe)
    else $error("SDA driven in standby");
  chk_reset_standby: assert property (@(posedge core_clk)
    disable iff (srst) $fell(srst) |-> standby)
    else $error("Not in standby after reset");
endmodule
bind twe_eeprom_slave twe_eeprom_slave_asserts twe_eeprom_slave_asserts_inst (
  .core_clk(core_clk), .linkClk(linkClk), .srst(srst), .standby(standby),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));

// >>> bench/twe_master.sv
`timescale 1ns/1ps
module twe_master (
  // Pacing clock
  input wire logic clk,
  // Bus drive and wire level
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaWire
);
  // Quarter bit in clocks; 2.8 us bits stay under 400 kHz
  localparam int Q = 7;
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic q();
    repeat (Q) @(posedge clk);
    #1;
  endtask
  // Also a repeated start when SCL is low
  task automatic start();
    sdaDrv = 1'b1;
    q();
    scl = 1'b1;
    q();
    sdaDrv = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sdaDrv = 1'b0;
    q();
    scl = 1'b1;
    q();
    sdaDrv = 1'b1;
    q();
  endtask
  task automatic bitIo(input logic b, output logic r);
    sdaDrv = b;
    q();
    scl = 1'b1;
    q();
    r = sdaWire;
    q();
    scl = 1'b0;
    q();
  endtask
  // Clocks until SDA reads high with SCL high, then starts
  task automatic recover(output int n);
    n = 0;
    sdaDrv = 1'b1;
    scl = 1'b1;
    q();
    while (!sdaWire && n < 9) begin
      scl = 1'b0;
      q();
      q();
      scl = 1'b1;
      q();
      n++;
    end
    sdaDrv = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask
  // MSB first, then the ninth clock
  task automatic xfer(input logic [7:0] d, input logic ackIn,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], r[i]);
    end
    bitIo(ackIn, ack);
  endtask
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
  nCompared++; \
  if ((g) !== (e)) begin \
    nMismatch++; \
    $display("FAIL t=%0t got %h exp %h", $time, g, e); \
  end \
end
module testbench;
  // Short write cycle keeps the run brief
  localparam int WCYC = 400;
  logic core_clk = 1'b0;
  logic linkClk = 1'b0;
  logic srst = 1'b1;
  logic standby, sdaOut, sdaOe, scl, sdaDrv, sdaWire;
  int nMismatch = 0;
  int nCompared = 0;
  // Pull-up wins unless someone pulls low
  assign sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #7;
    forever #24 linkClk = ~linkClk;
  end
  twe_eeprom_slave #(.WRITE_CYCLES(WCYC)) twe_eeprom_slave_inst (
    .core_clk(core_clk), .srst(srst), .standby(standby), .linkClk(linkClk),
    .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe));
  twe_master twe_master_inst (.clk(core_clk), .scl(scl), .sdaDrv(sdaDrv),
    .sdaWire(sdaWire));
  task automatic stopTest();
    $display("Compared %0d, mismatches %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic waitCyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic sendByte(input logic [7:0] d);
    logic [7:0] r;
    logic ack;
    twe_master_inst.xfer(d, 1'b1, r, ack);
    `CHK(ack, 1'b0)
  endtask
  task automatic writeSeq(input logic [6:0] a, input logic [7:0] d[$]);
    logic [7:0] r;
    logic ack;
    realtime t0;
    int n;
    twe_master_inst.start();
    sendByte({a, 1'b0});
    foreach (d[i]) sendByte(d[i]);
    twe_master_inst.stop();
    t0 = $realtime - 700.0;
    waitCyc(1);
    `CHK(standby, 1'b0)
    // Polling while the cycle runs must see no answer
    twe_master_inst.start();
    twe_master_inst.xfer({a, 1'b1}, 1'b1, r, ack);
    `CHK(ack, 1'b1)
    twe_master_inst.stop();
    n = 0;
    while (standby !== 1'b1 && n < 2 * WCYC) begin
      waitCyc(1);
      n++;
    end
    `CHK($realtime - t0 <= WCYC * 100.0, 1'b1)
  endtask
  task automatic readSeq(input logic [6:0] a, input logic [7:0] e[$]);
    logic [7:0] r;
    logic ack;
    twe_master_inst.start();
    sendByte({a, 1'b1});
    foreach (e[i]) begin
      twe_master_inst.xfer(8'hFF, i == e.size() - 1, r, ack);
      `CHK(r, e[i])
    end
    twe_master_inst.stop();
    waitCyc(4);
    `CHK(standby, 1'b1)
  endtask
  // Five bytes from 0x0E wrap inside page 0x0C..0x0F
  task automatic testPageWrap();
    writeSeq(7'h0E, '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4});
    readSeq(7'h0C, '{8'hA2, 8'hA3, 8'hA4, 8'hA1});
  endtask
  task automatic testReadWrap();
    writeSeq(7'h7E, '{8'hB0, 8'hB1});
    writeSeq(7'h00, '{8'hC5});
    readSeq(7'h7E, '{8'hB0, 8'hB1, 8'hC5});
  endtask
  // Repeated start drops a buffered write
  task automatic testAbort();
    logic [7:0] r;
    logic ack;
    writeSeq(7'h40, '{8'h33});
    twe_master_inst.start();
    sendByte({7'h40, 1'b0});
    sendByte(8'h11);
    twe_master_inst.start();
    sendByte({7'h40, 1'b1});
    twe_master_inst.xfer(8'hFF, 1'b1, r, ack);
    twe_master_inst.stop();
    `CHK(r, 8'h33)
    waitCyc(10);
    `CHK(standby, 1'b1)
  endtask
  // Master walks away mid-read while the slave holds SDA low
  task automatic testRecover();
    logic [7:0] r;
    logic ack;
    int n;
    twe_master_inst.start();
    sendByte({7'h0C, 1'b1});
    twe_master_inst.bitIo(1'b1, r[7]);
    `CHK(r[7], 1'b1)
    twe_master_inst.recover(n);
    `CHK(n, 1)
    sendByte({7'h0C, 1'b1});
    twe_master_inst.xfer(8'hFF, 1'b1, r, ack);
    twe_master_inst.stop();
    `CHK(r, 8'hA2)
    `CHK(ack, 1'b1)
    waitCyc(4);
    `CHK(standby, 1'b1)
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    srst = 1'b0;
    waitCyc(10);
    `CHK(standby, 1'b1)
    testPageWrap();
    testReadWrap();
    testAbort();
    testRecover();
    stopTest();
  end
  // Tests need just under 1 ms, about half the limit
  initial begin
    #2000000;
    nMismatch++;
    stopTest();
  end
endmodule
